// ===== verilog/ssr_core.sv
// serial shadow ram command port: decoder, latches, ram, transfers
//
// Behaviour
// - chip select high: standby, instruction register cleared
// - instruction shifted msb first on rising clock
// - bit7 one, bits6-3 address, bits2-0 operation
// - bits ignored until first one arrives
// - stopped serial clock pauses shifting in place
// - write-enable latch set/cleared, gates writes, store commands
// - power-up clears write-enable and save-enable latches
// - save-enable latch arms store on supply low
// - reload command or recall pin recalls, sets latch
// - power-up recall leaves previous-recall latch clear
// - store command needs write-enable and previous-recall latches
// - store blocks everything, then clears write-enable
// - store within 5 ms, recall within 2 us
// - write: address instruction then sixteen data bits
// - early deselect still writes received bits
// - bits beyond twenty-four overwrite the data word
// - read data valid during ninth clock
// - read data changes on falling clock
// - data output floats except during read data
// - commands ignored during power-up recall
// - store timed from eighth clock of instruction
`timescale 1ns/100ps
`include "ssr_params.svh"

module ssr_core #(
  parameter logic [`SSR_TIMER_W-1:0] STORE_CYCLES =
    `SSR_TIMER_W'(`SSR_STORE_CYC),
  parameter logic [`SSR_TIMER_W-1:0] PUR_CYCLES   =
    `SSR_TIMER_W'(`SSR_PUR_CYC)
) (
  input  wire logic SYS_CLK_I,
  input  wire logic NRST_I,
  input  wire logic CS_N_I,
  input  wire logic SCK_I,
  input  wire logic SI_I,
  input  wire logic RECALL_N_I,
  input  wire logic SUPPLY_LOW_I,
  output logic      SO_O,
  output logic      SO_OE_O,
  output logic      SUPPLY_LOW_OUT_N_O,
  output logic      SUPPLY_LOW_OUT_N_OE_O,
  output logic      BUSY_O,
  output logic      WRITE_EN_O,
  output logic      PREV_RECALL_O,
  output logic      SAVE_EN_O
);

  import ssr_pkg::*;

  // ----------------------------------------
  // timing constants
  // ----------------------------------------
  // recall length fixed, store and power-up set per instance
  localparam logic [`SSR_TIMER_W-1:0] RECALL_CYCLES =
    `SSR_TIMER_W'(`SSR_RECALL_CYC);
  localparam logic [`SSR_TIMER_W-1:0] TIMER_ONE = `SSR_TIMER_W'(1);

  // registered state and its next value
  ssr_state_type st;
  ssr_state_type next_st;
  ssr_array_type nv_rdata;

  // ----------------------------------------
  // nonvolatile array
  // ----------------------------------------
  ssr_nv_array #(
    .WORDS (`SSR_WORDS),
    .BITS  (`SSR_WORD_BITS)
  ) u_nv (
    .clk_i   (SYS_CLK_I),
    .we_i    (st.nv_we),
    .wdata_i (st.ram),
    .rdata_o (nv_rdata)
  );

  // ----------------------------------------
  // derived events from synchronised pins
  // ----------------------------------------
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic rcl_fall;
  logic low_rise;
  logic blocked;

  // edges read only second and third stages
  // pin stages reset to the idle pin levels, so no
  // false edge follows reset
  assign sck_rise = st.sck_s2 & ~st.sck_s3;
  assign sck_fall = ~st.sck_s2 & st.sck_s3;
  assign cs_rise  = st.cs_s2 & ~st.cs_s3;
  assign rcl_fall = ~st.rcl_s2 & st.rcl_s3;
  assign low_rise = st.low_s2 & ~st.low_s3;

  // serial port shut out during power-up recall and store
  assign blocked = (st.nv_state == NV_POWERUP) ||
                   (st.nv_state == NV_STORE);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [7:0] instr;
    logic [3:0] waddr;
    instr   = {st.shreg[6:0], st.si_s2};
    waddr   = st.addr;
    next_st = st;

    // two-stage synchronisers plus edge stage, none for si
    next_st.cs_s1  = CS_N_I;
    next_st.cs_s2  = st.cs_s1;
    next_st.cs_s3  = st.cs_s2;
    next_st.sck_s1 = SCK_I;
    next_st.sck_s2 = st.sck_s1;
    next_st.sck_s3 = st.sck_s2;
    next_st.si_s1  = SI_I;
    next_st.si_s2  = st.si_s1;
    next_st.rcl_s1 = RECALL_N_I;
    next_st.rcl_s2 = st.rcl_s1;
    next_st.rcl_s3 = st.rcl_s2;
    next_st.low_s1 = SUPPLY_LOW_I;
    next_st.low_s2 = st.low_s1;
    next_st.low_s3 = st.low_s2;
    next_st.nv_we  = 1'b0;

    // open-drain supply-low pin follows the detector
    next_st.as_oe = st.low_s2;

    // ----------------------------------------
    // transfer sequencer
    // ----------------------------------------
    case (st.nv_state)
      // power-up recall, commands shut out meanwhile
      NV_POWERUP: begin
        next_st.ram = nv_rdata;
        if (st.timer == '0) begin
          next_st.nv_state = NV_IDLE;
        end else begin
          next_st.timer = st.timer - TIMER_ONE;
        end
      end

      // recall already copied, only the busy time runs
      NV_RECALL: begin
        if (st.timer == '0) begin
          next_st.nv_state = NV_IDLE;
        end else begin
          next_st.timer = st.timer - TIMER_ONE;
        end
      end

      // store: array write strobe set on the last cycle, the copy lands one cycle later
      NV_STORE: begin
        if (st.timer == '0) begin
          next_st.nv_we    = 1'b1;
          next_st.wen      = 1'b0;
          next_st.nv_state = NV_IDLE;
        end else begin
          next_st.timer = st.timer - TIMER_ONE;
        end
      end

      // idle: power-loss save wins over a recall pin edge
      default: begin
        if (low_rise && st.save_en) begin
          next_st.nv_state = NV_STORE;
          next_st.timer    = STORE_CYCLES - TIMER_ONE;
        end else if (rcl_fall) begin
          next_st.ram      = nv_rdata;
          next_st.prev     = 1'b1;
          next_st.nv_state = NV_RECALL;
          next_st.timer    = RECALL_CYCLES - TIMER_ONE;
        end
      end
    endcase

    // ----------------------------------------
    // serial frame handling
    // ----------------------------------------
    if (st.cs_s2) begin
      // deselect: commit a partial or full write word
      if (cs_rise && st.ser_state == SER_WDATA && st.wen &&
          !blocked) begin
        next_st.ram[waddr] = st.wdata;
      end
      next_st.ser_state = SER_IDLE;
      next_st.shreg     = 8'h00;
      next_st.bitcnt    = 3'h0;
      next_st.so_oe     = 1'b0;
    end else if (blocked) begin
      next_st.ser_state = SER_HOLD;
      next_st.so_oe     = 1'b0;
    end else begin
      // no edge, no change: a stopped clock just waits
      case (st.ser_state)
        // hunt for the start bit, zeros dropped
        SER_IDLE: begin
          if (sck_rise && st.si_s2) begin
            next_st.shreg     = 8'h01;
            next_st.bitcnt    = 3'h1;
            next_st.ser_state = SER_CMD;
          end
        end

        // remaining seven instruction bits, then decode
        SER_CMD: begin
          if (sck_rise) begin
            next_st.shreg  = instr;
            next_st.bitcnt = st.bitcnt + 3'h1;
            if (st.bitcnt == 3'h7) begin
              next_st.addr      = instr[`SSR_ADDR_MSB:`SSR_ADDR_LSB];
              next_st.ser_state = SER_HOLD;
              case (ssr_op_type'(instr[`SSR_OP_MSB:0]))
                // clear the write-enable latch
                DISABLE_WRITE_CMD: begin
                  next_st.wen = 1'b0;
                end

                // store only with both latches set
                STORE_CMD: begin
                  if (st.wen && st.prev &&
                      st.nv_state == NV_IDLE) begin
                    next_st.nv_state = NV_STORE;
                    next_st.timer    = STORE_CYCLES - TIMER_ONE;
                  end
                end

                // arm the power-loss save
                ENABLE_SAVE_CMD: begin
                  next_st.save_en = 1'b1;
                end

                // start collecting the data word
                WRITE_CMD: begin
                  next_st.wdata     = 16'h0000;
                  next_st.wcnt      = 5'h00;
                  next_st.ser_state = SER_WDATA;
                end

                // set the write-enable latch
                ENABLE_WRITE_CMD: begin
                  next_st.wen = 1'b1;
                end

                // software recall, port stays open
                RELOAD_CMD: begin
                  next_st.ram      = nv_rdata;
                  next_st.prev     = 1'b1;
                  next_st.nv_state = NV_RECALL;
                  next_st.timer    = RECALL_CYCLES - TIMER_ONE;
                end
                default: begin
                  // read: last instruction bit ignored
                  next_st.rword     = st.ram[instr[6:3]];
                  next_st.rcnt      = 5'h00;
                  next_st.ser_state = SER_RDATA;
                end
              endcase
            end
          end
        end

        // data word, committed only at deselect
        SER_WDATA: begin
          if (sck_rise) begin
            // keeps shifting past sixteen bits
            next_st.wdata = {st.wdata[14:0], st.si_s2};
            if (st.wcnt != 5'h10) begin
              next_st.wcnt = st.wcnt + 5'h01;
            end
          end
        end

        // read word out on falling clock edges
        SER_RDATA: begin
          if (sck_fall) begin
            if (st.rcnt != 5'h10) begin
              next_st.so    = st.rword[15];
              next_st.so_oe = 1'b1;
              next_st.rword = {st.rword[14:0], 1'b0};
              next_st.rcnt  = st.rcnt + 5'h01;
            end else begin
              next_st.so_oe     = 1'b0;
              next_st.ser_state = SER_HOLD;
            end
          end
        end

        default: begin
          // wait for deselect before the next command
          next_st.ser_state = SER_HOLD;
        end
      endcase
    end

    // busy follows the sequencer state being entered
    next_st.busy = (next_st.nv_state != NV_IDLE);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      // clear all, then the select and recall pin stages, states, timer, busy and latches
      st           <= '0;
      st.cs_s1     <= `SSR_CS_RST;
      st.cs_s2     <= `SSR_CS_RST;
      st.cs_s3     <= `SSR_CS_RST;
      st.rcl_s1    <= `SSR_RCL_RST;
      st.rcl_s2    <= `SSR_RCL_RST;
      st.rcl_s3    <= `SSR_RCL_RST;
      st.ser_state <= SER_IDLE;
      st.nv_state  <= NV_POWERUP;
      st.timer     <= PUR_CYCLES - TIMER_ONE;
      st.busy      <= 1'b1;
      st.wen       <= `SSR_LATCH_RST;
      st.save_en   <= `SSR_LATCH_RST;
      st.prev      <= `SSR_LATCH_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs, all but the constant supply-low value from state flops
  // ----------------------------------------
  assign SO_O                  = st.so;
  assign SO_OE_O               = st.so_oe;

  // open-drain pin: value low, the enable pulls it
  assign SUPPLY_LOW_OUT_N_O    = 1'b0;
  assign SUPPLY_LOW_OUT_N_OE_O = st.as_oe;

  // latch and busy flags for the host side
  assign BUSY_O                = st.busy;
  assign WRITE_EN_O            = st.wen;
  assign PREV_RECALL_O         = st.prev;
  assign SAVE_EN_O             = st.save_en;

endmodule

// ===== common/ssr_params.svh
// constants for the serial shadow ram command port
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define SSR_CLK_PERIOD_NS  25
`define SSR_STORE_TIME_MS  5
`define SSR_RECALL_TIME_US 2
`define SSR_PUR_TIME_US    200
`define SSR_STORE_CYC  ((`SSR_STORE_TIME_MS * 1000000) / `SSR_CLK_PERIOD_NS)
`define SSR_RECALL_CYC ((`SSR_RECALL_TIME_US * 1000) / `SSR_CLK_PERIOD_NS)
`define SSR_PUR_CYC    ((`SSR_PUR_TIME_US * 1000) / `SSR_CLK_PERIOD_NS)
`define SSR_TIMER_W    18

// ----------------------------------------
// geometry and instruction fields
// ----------------------------------------
`define SSR_WORDS      16
`define SSR_WORD_BITS  16
`define SSR_INSTR_BITS 8
`define SSR_START_BIT  7
`define SSR_ADDR_MSB   6
`define SSR_ADDR_LSB   3
`define SSR_OP_MSB     2

// ----------------------------------------
// reset values
// ----------------------------------------
`define SSR_LATCH_RST  1'b0
`define SSR_CS_RST     1'b1
`define SSR_RCL_RST    1'b1

`endif

// ===== common/ssr_pkg.sv
// types of the serial shadow ram command port
`include "ssr_params.svh"

package ssr_pkg;

  // ----------------------------------------
  // operation codes, low three instruction bits
  // ----------------------------------------
  typedef enum logic [2:0] {
    DISABLE_WRITE_CMD = 3'h0,
    STORE_CMD         = 3'h1,
    ENABLE_SAVE_CMD   = 3'h2,
    WRITE_CMD         = 3'h3,
    ENABLE_WRITE_CMD  = 3'h4,
    RELOAD_CMD        = 3'h5,
    READ_CMD          = 3'h6,
    READ_ALT_CMD      = 3'h7
  } ssr_op_type;

  // ----------------------------------------
  // serial frame states, gray for idle-cmd-wdata, rdata-hold and rdata-idle steps
  // ----------------------------------------
  typedef enum logic [2:0] {
    SER_IDLE  = 3'h0,
    SER_CMD   = 3'h1,
    SER_WDATA = 3'h3,
    SER_RDATA = 3'h2,
    SER_HOLD  = 3'h6
  } ssr_ser_type;

  // ----------------------------------------
  // transfer sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    NV_POWERUP = 2'h0,
    NV_IDLE    = 2'h1,
    NV_RECALL  = 2'h3,
    NV_STORE   = 2'h2
  } ssr_nv_type;

  typedef logic [`SSR_WORDS-1:0][`SSR_WORD_BITS-1:0] ssr_array_type;

  // ----------------------------------------
  // whole state of the command port
  // ----------------------------------------
  typedef struct packed {
    logic                    cs_s1;
    logic                    cs_s2;
    logic                    cs_s3;
    logic                    sck_s1;
    logic                    sck_s2;
    logic                    sck_s3;
    logic                    si_s1;
    logic                    si_s2;
    logic                    rcl_s1;
    logic                    rcl_s2;
    logic                    rcl_s3;
    logic                    low_s1;
    logic                    low_s2;
    logic                    low_s3;
    ssr_ser_type             ser_state;
    ssr_nv_type              nv_state;
    logic [7:0]              shreg;
    logic [2:0]              bitcnt;
    logic [3:0]              addr;
    logic [15:0]             wdata;
    logic [4:0]              wcnt;
    logic [15:0]             rword;
    logic [4:0]              rcnt;
    logic                    so;
    logic                    so_oe;
    logic                    as_oe;
    logic                    wen;
    logic                    prev;
    logic                    save_en;
    logic                    busy;
    logic                    nv_we;
    logic [`SSR_TIMER_W-1:0] timer;
    ssr_array_type           ram;
  } ssr_state_type;

endpackage

// ===== verilog/ssr_nv_array.sv
// nonvolatile shadow array, kept across the logic reset
`timescale 1ns/100ps

module ssr_nv_array #(
  parameter int WORDS = 16,
  parameter int BITS  = 16
) (
  input  wire logic                       clk_i,
  input  wire logic                       we_i,
  input  wire logic [WORDS-1:0][BITS-1:0] wdata_i,
  output logic      [WORDS-1:0][BITS-1:0] rdata_o
);

  logic [WORDS-1:0][BITS-1:0] cells;

  // ----------------------------------------
  // whole-array copy, no reset so contents survive
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      cells <= wdata_i;
    end
  end

  assign rdata_o = cells;

endmodule

// ===== testbench/ssr_host_model.sv
// host side model: drives one serial frame in mode 0,0
`timescale 1ns/100ps

module ssr_host_model (
  input  wire logic sys_clk_i,
  input  wire logic so_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end

  // n bits msb first, so sampled in each high phase
  task automatic xfer(input logic [31:0] bits, input int n,
                      output logic [15:0] rd);
    rd = '0;
    @(posedge sys_clk_i) cs_n_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      if (i == n - 5) repeat (40) @(posedge sys_clk_i);
      si_o <= bits[i];
      repeat (4) @(posedge sys_clk_i);
      sck_o <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rd = {rd[14:0], so_i};
      repeat (2) @(posedge sys_clk_i);
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge sys_clk_i);
    cs_n_o <= 1'b1;
    si_o   <= ~si_o; // released line shows no stale value
    repeat (8) @(posedge sys_clk_i);
  endtask
endmodule

// ===== testbench/ssr_core_sva.sv
// assertions on the pins of the serial shadow ram command port
`timescale 1ns/100ps
`include "ssr_params.svh"

module ssr_core_sva #(
  parameter logic [`SSR_TIMER_W-1:0] STORE_CYCLES =
    `SSR_TIMER_W'(`SSR_STORE_CYC)
) (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic CS_N_I,
  input wire logic RECALL_N_I,
  input wire logic SUPPLY_LOW_I,
  input wire logic SO_OE_O,
  input wire logic SUPPLY_LOW_OUT_N_O,
  input wire logic SUPPLY_LOW_OUT_N_OE_O,
  input wire logic BUSY_O,
  input wire logic WRITE_EN_O,
  input wire logic PREV_RECALL_O,
  input wire logic SAVE_EN_O
);
  logic [`SSR_TIMER_W-1:0] busy_len;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);

  // length of the running busy stretch
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      busy_len <= '0;
    end else if (BUSY_O) begin
      busy_len <= busy_len + 1'b1;
    end else begin
      busy_len <= '0;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_pur_latches: assert property (
    $rose(NRST_I) |->
      (BUSY_O && !WRITE_EN_O && !PREV_RECALL_O && !SAVE_EN_O) [*8])
    else $error("latch set or idle during power-up recall");
  a_deselect_float: assert property (
    CS_N_I [*6] |-> !SO_OE_O)
    else $error("data out driven while deselected");
  a_oe_selected: assert property (
    $rose(SO_OE_O) |-> !CS_N_I)
    else $error("data out enabled without select");
  a_store_time: assert property (
    busy_len <= STORE_CYCLES + 18'd4)
    else $error("busy held beyond store time");
  a_store_wen: assert property (
    $fell(BUSY_O) && busy_len > 18'd100 |-> ##[0:2] !WRITE_EN_O)
    else $error("write enable kept after store");
  a_recall_prev: assert property (
    $fell(RECALL_N_I) && !BUSY_O ##1 !RECALL_N_I [*4]
      |-> ##[0:4] PREV_RECALL_O)
    else $error("recall pin did not set recall latch");
  a_save_start: assert property (
    $rose(SUPPLY_LOW_I) && SAVE_EN_O && !BUSY_O ##1 SUPPLY_LOW_I [*4]
      |-> ##[0:4] BUSY_O)
    else $error("supply low did not start a save");
  a_supply_pin: assert property (
    SUPPLY_LOW_I [*6] |-> SUPPLY_LOW_OUT_N_OE_O && !SUPPLY_LOW_OUT_N_O)
    else $error("supply low pin not pulled");

  c_store: cover property ($fell(BUSY_O) && busy_len > 18'd100);
  c_read: cover property ($rose(SO_OE_O));
  c_recall: cover property ($rose(PREV_RECALL_O));
endmodule

// ===== testbench/ssr_core_test.sv
// self-checking bench for the serial shadow ram command port
`timescale 1ns/100ps

module ssr_core_test;
  import ssr_pkg::*;
  logic        sys_clk = 1'b0, nrst = 1'b0;
  logic        recall_n = 1'b1, supply_low = 1'b0;
  logic        cs_n, sck, si, so, so_oe, as_n, as_oe;
  logic        busy, wen, prev, save_en;
  logic [15:0] rd;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;

  ssr_core #(.STORE_CYCLES(18'd200), .PUR_CYCLES(18'd20)) ssr_core_inst (
    .SYS_CLK_I(sys_clk), .NRST_I(nrst), .CS_N_I(cs_n), .SCK_I(sck),
    .SI_I(si), .RECALL_N_I(recall_n), .SUPPLY_LOW_I(supply_low),
    .SO_O(so), .SO_OE_O(so_oe), .SUPPLY_LOW_OUT_N_O(as_n),
    .SUPPLY_LOW_OUT_N_OE_O(as_oe), .BUSY_O(busy), .WRITE_EN_O(wen),
    .PREV_RECALL_O(prev), .SAVE_EN_O(save_en));
  ssr_host_model ssr_host_model_inst (.sys_clk_i(sys_clk),
    .so_i(so_oe ? so : 1'bz), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

  initial forever #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] flags();
    return {12'h0, busy, wen, prev, save_en};
  endfunction
  task automatic cmd(input ssr_op_type op);
    ssr_host_model_inst.xfer({24'h0, 1'b1, 4'h0, op}, 8, rd);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    ssr_host_model_inst.xfer({8'h0, 1'b1, a, WRITE_CMD, d}, 24, rd);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    ssr_host_model_inst.xfer({8'h0, 1'b1, a, READ_CMD, 16'h0}, 24, rd);
    chk(rd, exp, "read word");
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge sys_clk);
    chk(flags() & 16'h8, 16'h0, "busy");
  endtask
  task automatic pulse_recall();
    recall_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    recall_n <= 1'b1;
    wait_idle();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_powerup();
    @(posedge sys_clk);
    chk(flags(), 16'h8, "reset flags");
    cmd(ENABLE_WRITE_CMD);
    wait_idle();
    chk(flags(), 16'h0, "after power-up");
    $display("test power-up done");
  endtask
  task automatic t_write_read();
    cmd(ENABLE_WRITE_CMD);
    chk(flags(), 16'h4, "write enable");
    wr(4'h5, 16'ha5c3);
    wr(4'ha, 16'h1234);
    ssr_host_model_inst.xfer({8'h0, 1'b1, 4'h3, WRITE_CMD, 16'h0ff0},
                             27, rd);
    ssr_host_model_inst.xfer({16'h0, 1'b1, 4'h7, WRITE_CMD, 8'hc3},
                             16, rd);
    ssr_host_model_inst.xfer({4'h0, 1'b1, 4'h9, WRITE_CMD, 20'habcde},
                             28, rd);
    rd_chk(4'h5, 16'ha5c3);
    rd_chk(4'h3, 16'h0ff0);
    rd_chk(4'h7, 16'h00c3);
    rd_chk(4'h9, 16'hbcde);
    ssr_host_model_inst.xfer({8'h0, 1'b1, 4'ha, READ_ALT_CMD, 16'h0},
                             24, rd);
    chk(rd, 16'h1234, "read alternate");
    cmd(DISABLE_WRITE_CMD);
    chk(flags(), 16'h0, "write disable");
    wr(4'h5, 16'hffff);
    rd_chk(4'h5, 16'ha5c3);
    $display("test write and read done");
  endtask
  task automatic t_store();
    cmd(STORE_CMD);
    chk(flags(), 16'h0, "store refused");
    cmd(RELOAD_CMD);
    wait_idle();
    chk(flags(), 16'h2, "reload");
    cmd(ENABLE_WRITE_CMD);
    wr(4'h2, 16'h5aa5);
    cmd(STORE_CMD);
    chk(flags(), 16'he, "store running");
    wait_idle();
    chk(flags(), 16'h2, "store done");
    cmd(ENABLE_WRITE_CMD);
    wr(4'h2, 16'h0001);
    rd_chk(4'h2, 16'h0001);
    pulse_recall();
    rd_chk(4'h2, 16'h5aa5);
    $display("test store and recall done");
  endtask
  task automatic t_autosave();
    cmd(ENABLE_SAVE_CMD);
    wr(4'h2, 16'h0777);
    chk(flags(), 16'h7, "save enabled");
    supply_low <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk({14'h0, as_oe, busy}, 16'h3, "save start");
    wait_idle();
    supply_low <= 1'b0;
    chk(flags(), 16'h3, "save done");
    pulse_recall();
    rd_chk(4'h2, 16'h0777);
    $display("test power-loss save done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    t_powerup();
    t_write_read();
    t_store();
    t_autosave();
    print_verdict();
  end
endmodule

bind ssr_core ssr_core_sva #(.STORE_CYCLES(STORE_CYCLES)) ssr_core_sva_inst (
  .SYS_CLK_I, .NRST_I, .CS_N_I, .RECALL_N_I, .SUPPLY_LOW_I, .SO_OE_O,
  .SUPPLY_LOW_OUT_N_O, .SUPPLY_LOW_OUT_N_OE_O, .BUSY_O, .WRITE_EN_O,
  .PREV_RECALL_O, .SAVE_EN_O);
